// ---- core/erfe_defs.svh ----
`ifndef ERFE_DEFS_SVH
`define ERFE_DEFS_SVH
// Function
// - strip valid preamble/delimiter header, else discard
// - need one delimiter byte, any preambles before
// - two zero bits before delimiter discard frame
// - address recognition after six bytes
// - append 32-bit status word with length, flags
// - buffer and frame events, mask gated interrupt
// - descriptor: set end, write status, clear vacant
// - set frame event after descriptor update
// - flag bit plus mask bit asserts interrupt
// - write one clears flag, zero keeps
// - event flags zero after reset
// - provide operational and fault event flags
// - error events bump counters regardless of mask
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ERFE_OFS_EVENT_FLAGS 12'h004
`define ERFE_OFS_EVENT_MASK 12'h008
`define ERFE_OFS_RX_CTRL 12'h084
`define ERFE_OFS_ADDR_LOW 12'h0E4
`define ERFE_OFS_ADDR_HIGH 12'h0E8
`define ERFE_OFS_HASH_UPPER 12'h120
`define ERFE_OFS_HASH_LOWER 12'h124
`define ERFE_OFS_CNT_CRC 12'h200
`define ERFE_OFS_CNT_LONG 12'h204
`define ERFE_OFS_CNT_SPILL 12'h208
// ----------------------------------------------------------------
// event flag bit positions
// ----------------------------------------------------------------
`define ERFE_EV_HEARTBEAT_ERR 31
`define ERFE_EV_BABBLE_RX 30
`define ERFE_EV_BABBLE_TX 29
`define ERFE_EV_ORDERLY_HALT 28
`define ERFE_EV_TX_FRAME 27
`define ERFE_EV_TX_BUFFER 26
`define ERFE_EV_RX_FRAME 25
`define ERFE_EV_RX_BUFFER 24
`define ERFE_EV_LATE_COLL 21
`define ERFE_EV_RETRY_LIMIT 20
`define ERFE_EV_TX_STARVED 19
`define ERFE_EV_IMPL_MASK 32'hFF380000
// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define ERFE_ST_MISS 31
`define ERFE_ST_BCAST 30
`define ERFE_ST_MCAST 29
`define ERFE_ST_LONG 28
`define ERFE_ST_ODD 27
`define ERFE_ST_CRC 26
`define ERFE_ST_SPILL 25
`define ERFE_ST_CUT 24
`define ERFE_ST_LEN_W 16
// ----------------------------------------------------------------
// descriptor bits
// ----------------------------------------------------------------
`define ERFE_BD_VACANT 15
`define ERFE_BD_LAST 11
// ----------------------------------------------------------------
// framing constants
// ----------------------------------------------------------------
`define ERFE_SFD_BYTE 8'hD5
`define ERFE_PRE_NIB 4'h5
`define ERFE_ADDR_BYTES 16'h0006
`define ERFE_MAX_LEN_RST 16'h05EE
`define ERFE_CRC_INIT 32'hFFFFFFFF
`define ERFE_CRC_RESIDUE 32'hC704DD7B
`define ERFE_CRC_POLY 32'h04C11DB7
`endif

// ---- core/erfe_pkg.sv ----
package erfe_pkg;
	typedef enum logic [2:0] {
		ERFE_IDLE,
		ERFE_HUNT,
		ERFE_DATA,
		ERFE_DROP,
		ERFE_STAT,
		ERFE_DESC,
		ERFE_FLAG
	} erfe_state_t;
endpackage : erfe_pkg

// ---- core/erfe_crc.sv ----
`timescale 1ns/100ps
`include "erfe_defs.svh"
// running crc over one nibble
module erfe_crc (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// control and data
	input wire logic clear_in,
	input wire logic step_in,
	input wire logic [3:0] nib_in,
	// state
	output logic crc_good_out
);
	logic [31:0] crc_q;
	logic [31:0] crc_d;
	// ----------------------------------------------------------------
	// nibble update, lsb first
	// ----------------------------------------------------------------
	always_comb begin
		crc_d = crc_q;
		for (int i = 0; i < 4; i++) begin
			if (crc_d[31] ^ nib_in[i]) begin
				crc_d = {crc_d[30:0], 1'b0} ^ `ERFE_CRC_POLY;
			end else begin
				crc_d = {crc_d[30:0], 1'b0};
			end
		end
	end
	// register
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || clear_in) begin
			crc_q <= `ERFE_CRC_INIT;
		end else if (step_in) begin
			crc_q <= crc_d;
		end
	end
	// residue left once an intact checksum has passed through
	always_comb begin
		crc_good_out = 1'b0;
		if (crc_q == `ERFE_CRC_RESIDUE) begin
			crc_good_out = 1'b1;
		end
	end
endmodule : erfe_crc

// ---- core/erfe_cnt.sv ----
`timescale 1ns/100ps
// saturating statistics counter
module erfe_cnt #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// event
	input wire logic bump_in,
	// value
	output logic [W-1:0] count_out
);
	// count, hold at maximum
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			count_out <= '0;
		end else if (bump_in && !(&count_out)) begin
			count_out <= count_out + 1'b1;
		end
	end
endmodule : erfe_cnt

// ---- core/erfe_rx.sv ----
`timescale 1ns/100ps
`include "erfe_defs.svh"
module erfe_rx #(
	parameter int CW = 16
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// mii receive, one nibble per strobe
	input wire logic rx_dv_in,
	input wire logic rx_er_in,
	input wire logic rx_nib_en_in,
	input wire logic [3:0] rxd_in,
	// receive fifo write
	output logic fifo_wr_out,
	output logic [31:0] fifo_data_out,
	output logic fifo_stat_out,
	input wire logic fifo_full_in,
	// descriptor write
	output logic desc_wr_out,
	output logic [15:0] desc_out,
	// other event sources
	input wire logic [31:0] ext_events_in,
	// register port
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// interrupt
	output logic irq_out,
	// receiver state
	output logic rx_busy_out
);
	erfe_pkg::erfe_state_t state_q;
	logic [31:0] flags_q;
	logic [31:0] mask_q;
	logic [31:0] hash_up_q;
	logic [31:0] hash_lo_q;
	logic [31:0] addr_lo_q;
	logic [15:0] addr_hi_q;
	logic [15:0] max_len_q;
	logic en_q;
	logic prom_q;
	logic prev_zero_q;
	logic half_q;
	logic [3:0] lo_nib_q;
	logic [15:0] len_q;
	logic [47:0] da_q;
	logic [1:0] bidx_q;
	logic [31:0] word_q;
	logic miss_q, bcast_q, mcast_q, long_q, odd_q, spill_q, cut_q, crc_bad_q;
	logic [31:0] stat_q;
	logic crc_good;
	logic [CW-1:0] cnt_crc, cnt_long, cnt_spill;
	logic ev_rx_frame, ev_rx_buf;
	logic [7:0] byte_v;
	logic [5:0] hidx;
	logic hash_hit;
	logic crc_clr;
	logic crc_step;
	assign byte_v = {rxd_in, lo_nib_q};
	assign crc_clr = (state_q == erfe_pkg::ERFE_HUNT);
	assign crc_step = (state_q == erfe_pkg::ERFE_DATA) && rx_dv_in && rx_nib_en_in;
	assign rx_busy_out = (state_q != erfe_pkg::ERFE_IDLE);
	// ----------------------------------------------------------------
	// frame checker and counters
	// ----------------------------------------------------------------
	erfe_crc u_crc (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.clear_in(crc_clr),
		.step_in(crc_step),
		.nib_in(rxd_in),
		.crc_good_out(crc_good)
	);
	// error events counted whatever the mask
	erfe_cnt #(.W(CW)) u_cnt_crc (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.bump_in(state_q == erfe_pkg::ERFE_STAT && crc_bad_q),
		.count_out(cnt_crc)
	);
	erfe_cnt #(.W(CW)) u_cnt_long (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.bump_in(state_q == erfe_pkg::ERFE_STAT && long_q),
		.count_out(cnt_long)
	);
	erfe_cnt #(.W(CW)) u_cnt_spill (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.bump_in(state_q == erfe_pkg::ERFE_STAT && spill_q),
		.count_out(cnt_spill)
	);
	// ----------------------------------------------------------------
	// receive state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state_q <= erfe_pkg::ERFE_IDLE;
			prev_zero_q <= 1'b0;
			half_q <= 1'b0;
			lo_nib_q <= 4'h0;
		end else begin
			case (state_q)
				erfe_pkg::ERFE_IDLE: begin
					if (en_q && !rx_dv_in) begin
						state_q <= erfe_pkg::ERFE_HUNT;
					end
					half_q <= 1'b0;
					prev_zero_q <= 1'b0;
				end
				erfe_pkg::ERFE_HUNT: begin
					// any preambles, then one delimiter byte
					if (rx_dv_in && rx_nib_en_in) begin
						lo_nib_q <= rxd_in;
						prev_zero_q <= ~rxd_in[3];
						if ((prev_zero_q && !rxd_in[0]) || (rxd_in[1:0] == 2'b00) ||
								(rxd_in[2:1] == 2'b00) || (rxd_in[3:2] == 2'b00)) begin
							state_q <= erfe_pkg::ERFE_DROP;
						end else if (byte_v == `ERFE_SFD_BYTE) begin
							state_q <= erfe_pkg::ERFE_DATA;
							half_q <= 1'b0;
						end
					end else if (!rx_dv_in && prev_zero_q != 1'b0) begin
						prev_zero_q <= 1'b0;
					end
				end
				erfe_pkg::ERFE_DATA: begin
					if (!rx_dv_in) begin
						state_q <= erfe_pkg::ERFE_STAT;
					end else if (rx_nib_en_in) begin
						half_q <= ~half_q;
						lo_nib_q <= rxd_in;
					end
				end
				erfe_pkg::ERFE_DROP: begin
					// discarded frame leaves no trace
					if (!rx_dv_in) begin
						state_q <= erfe_pkg::ERFE_IDLE;
					end
				end
				erfe_pkg::ERFE_STAT: begin
					if (!fifo_full_in) begin
						state_q <= erfe_pkg::ERFE_DESC;
					end
				end
				erfe_pkg::ERFE_DESC: begin
					state_q <= erfe_pkg::ERFE_FLAG;
				end
				erfe_pkg::ERFE_FLAG: begin
					state_q <= erfe_pkg::ERFE_IDLE;
				end
				default: begin
					state_q <= erfe_pkg::ERFE_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// byte assembly, length and address capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || state_q == erfe_pkg::ERFE_HUNT) begin
			len_q <= 16'h0000;
			da_q <= 48'h0;
			bidx_q <= 2'b00;
			word_q <= 32'h0;
		end else if (state_q == erfe_pkg::ERFE_DATA && rx_dv_in && rx_nib_en_in && half_q) begin
			len_q <= len_q + 16'h0001;
			if (len_q < `ERFE_ADDR_BYTES) begin
				da_q <= {da_q[39:0], byte_v};
			end
			word_q[bidx_q*8 +: 8] <= byte_v;
			bidx_q <= bidx_q + 2'b01;
		end else if (state_q == erfe_pkg::ERFE_STAT) begin
			bidx_q <= 2'b00;
		end
	end
	// hash index: xor of the low six bits of each address byte
	assign hidx = da_q[5:0] ^ da_q[13:8] ^ da_q[21:16] ^ da_q[29:24] ^ da_q[37:32] ^ da_q[45:40];
	assign hash_hit = hidx[5] ? hash_up_q[hidx[4:0]] : hash_lo_q[hidx[4:0]];
	// ----------------------------------------------------------------
	// error and address flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || state_q == erfe_pkg::ERFE_HUNT) begin
			{miss_q, bcast_q, mcast_q, long_q, odd_q, spill_q, cut_q, crc_bad_q} <= 8'h00;
		end else if (state_q == erfe_pkg::ERFE_DATA) begin
			if (len_q == `ERFE_ADDR_BYTES && !half_q) begin
				// recognition once six bytes are in
				bcast_q <= &da_q;
				mcast_q <= da_q[40] && !(&da_q);
				miss_q <= !prom_q && !(&da_q) && !(da_q[40] && hash_hit) &&
					(da_q != {addr_lo_q, addr_hi_q});
			end
			if (rx_dv_in && rx_er_in) begin
				crc_bad_q <= 1'b1;
			end
			if (len_q > max_len_q) begin
				long_q <= 1'b1;
				cut_q <= 1'b1;
			end
			if (fifo_wr_out && fifo_full_in) begin
				spill_q <= 1'b1;
			end
			if (!rx_dv_in) begin
				odd_q <= half_q;
				crc_bad_q <= crc_bad_q || !crc_good;
			end
		end
	end
	// ----------------------------------------------------------------
	// fifo writes: data words, then status word
	// ----------------------------------------------------------------
	always_comb begin
		stat_q = 32'h0;
		stat_q[`ERFE_ST_MISS] = miss_q;
		stat_q[`ERFE_ST_BCAST] = bcast_q;
		stat_q[`ERFE_ST_MCAST] = mcast_q;
		stat_q[`ERFE_ST_LONG] = long_q;
		stat_q[`ERFE_ST_ODD] = odd_q;
		stat_q[`ERFE_ST_CRC] = crc_bad_q;
		stat_q[`ERFE_ST_SPILL] = spill_q;
		stat_q[`ERFE_ST_CUT] = cut_q;
		stat_q[`ERFE_ST_LEN_W-1:0] = len_q;
	end
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			fifo_wr_out <= 1'b0;
			fifo_data_out <= 32'h0;
			fifo_stat_out <= 1'b0;
		end else begin
			fifo_wr_out <= 1'b0;
			fifo_stat_out <= 1'b0;
			if (state_q == erfe_pkg::ERFE_DATA && !cut_q && rx_dv_in && rx_nib_en_in && half_q &&
					bidx_q == 2'b11) begin
				fifo_wr_out <= 1'b1;
				fifo_data_out <= {byte_v, word_q[23:0]};
			end else if (state_q == erfe_pkg::ERFE_DATA && !rx_dv_in && bidx_q != 2'b00) begin
				fifo_wr_out <= 1'b1;
				fifo_data_out <= word_q;
			end else if (state_q == erfe_pkg::ERFE_STAT && !fifo_full_in) begin
				fifo_wr_out <= 1'b1;
				fifo_stat_out <= 1'b1;
				fifo_data_out <= stat_q;
			end
		end
	end
	// ----------------------------------------------------------------
	// descriptor update
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			desc_wr_out <= 1'b0;
			desc_out <= 16'h0;
		end else begin
			desc_wr_out <= (state_q == erfe_pkg::ERFE_DESC);
			if (state_q == erfe_pkg::ERFE_DESC) begin
				desc_out <= {1'b0, 3'b000, 1'b1, miss_q, bcast_q, mcast_q, long_q, odd_q, 1'b0,
					crc_bad_q, spill_q, cut_q, 2'b00};
			end
		end
	end
	// ----------------------------------------------------------------
	// events: rx buffer on each fifo data word, rx frame after descriptor
	// ----------------------------------------------------------------
	assign ev_rx_buf = fifo_wr_out && !fifo_stat_out;
	assign ev_rx_frame = (state_q == erfe_pkg::ERFE_FLAG);
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			flags_q <= 32'h0;
		end else begin
			// set wins over a same-cycle clear
			flags_q <= ((reg_wr_in && reg_addr_in == `ERFE_OFS_EVENT_FLAGS) ?
				(flags_q & ~reg_wdata_in) : flags_q) |
				(ext_events_in & `ERFE_EV_IMPL_MASK) |
				({31'h0, ev_rx_frame} << `ERFE_EV_RX_FRAME) | ({31'h0, ev_rx_buf} << `ERFE_EV_RX_BUFFER);
		end
	end
	// interrupt when flag and mask coincide
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(flags_q & mask_q);
		end
	end
	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mask_q <= 32'h0;
			hash_up_q <= 32'h0;
			hash_lo_q <= 32'h0;
			addr_lo_q <= 32'h0;
			addr_hi_q <= 16'h0;
			max_len_q <= `ERFE_MAX_LEN_RST;
			en_q <= 1'b0;
			prom_q <= 1'b0;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`ERFE_OFS_EVENT_MASK: mask_q <= reg_wdata_in & `ERFE_EV_IMPL_MASK;
				`ERFE_OFS_HASH_UPPER: hash_up_q <= reg_wdata_in;
				`ERFE_OFS_HASH_LOWER: hash_lo_q <= reg_wdata_in;
				`ERFE_OFS_ADDR_LOW: addr_lo_q <= reg_wdata_in;
				`ERFE_OFS_ADDR_HIGH: addr_hi_q <= reg_wdata_in[31:16];
				`ERFE_OFS_RX_CTRL: begin
					max_len_q <= reg_wdata_in[31:16];
					prom_q <= reg_wdata_in[3];
					en_q <= reg_wdata_in[0];
				end
				default: begin
				end
			endcase
		end
	end
	// read data, one cycle after strobe, zero otherwise
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !reg_rd_in) begin
			reg_rdata_out <= 32'h0;
		end else begin
			case (reg_addr_in)
				`ERFE_OFS_EVENT_FLAGS: reg_rdata_out <= flags_q;
				`ERFE_OFS_EVENT_MASK: reg_rdata_out <= mask_q;
				`ERFE_OFS_HASH_UPPER: reg_rdata_out <= hash_up_q;
				`ERFE_OFS_HASH_LOWER: reg_rdata_out <= hash_lo_q;
				`ERFE_OFS_ADDR_LOW: reg_rdata_out <= addr_lo_q;
				`ERFE_OFS_ADDR_HIGH: reg_rdata_out <= {addr_hi_q, 16'h0};
				`ERFE_OFS_RX_CTRL: reg_rdata_out <= {max_len_q, 12'h0, prom_q, 2'b00, en_q};
				`ERFE_OFS_CNT_CRC: reg_rdata_out <= 32'(cnt_crc);
				`ERFE_OFS_CNT_LONG: reg_rdata_out <= 32'(cnt_long);
				`ERFE_OFS_CNT_SPILL: reg_rdata_out <= 32'(cnt_spill);
				default: reg_rdata_out <= 32'h0;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_desc_then_flag;
		desc_wr_out ##0 (state_q == erfe_pkg::ERFE_FLAG);
	endsequence
	chk_flag_after_desc: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		s_desc_then_flag |=> flags_q[`ERFE_EV_RX_FRAME]) else $error("frame event missing after descriptor");
	chk_desc_last_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		desc_wr_out |-> desc_out[`ERFE_BD_LAST] && !desc_out[`ERFE_BD_VACANT]) else $error("descriptor bits wrong");
	chk_drop_no_write: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		$past(state_q) == erfe_pkg::ERFE_DROP |-> !fifo_wr_out) else $error("write from dropped frame");
	chk_stat_word_len: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		fifo_stat_out |-> fifo_wr_out && fifo_data_out[`ERFE_ST_LEN_W-1:0] == len_q)
		else $error("status word length wrong");
	chk_irq_gate: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		irq_out |-> |($past(flags_q) & $past(mask_q))) else $error("unmasked interrupt");
	chk_clear_by_one: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		reg_wr_in && reg_addr_in == `ERFE_OFS_EVENT_FLAGS && !ext_events_in[`ERFE_EV_TX_FRAME] &&
		reg_wdata_in[`ERFE_EV_TX_FRAME] |=> !flags_q[`ERFE_EV_TX_FRAME]) else $error("flag not cleared");
	chk_reset_flags: assert property (@(posedge clk_sys_in)
		srst_in |=> flags_q == 32'h0) else $error("flags not zero after reset");
	chk_zero_pair: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		state_q == erfe_pkg::ERFE_HUNT && rx_dv_in && rx_nib_en_in && rxd_in[1:0] == 2'b00
		|=> state_q == erfe_pkg::ERFE_DROP) else $error("zero pair not dropped");
	chk_rxb_event: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		fifo_wr_out && !fifo_stat_out |=> flags_q[`ERFE_EV_RX_BUFFER]) else $error("buffer event missing");
endmodule : erfe_rx

// ---- tb/erfe_phy_model.sv ----
`timescale 1ns/100ps
// transceiver receive side: one nibble per strobe slot
module erfe_phy_model #(
	parameter int GAP = 4
) (
	// clock
	input wire logic clk_sys_in,
	// mii receive
	output logic rx_dv_out,
	output logic rx_er_out,
	output logic rx_nib_en_out,
	output logic [3:0] rxd_out
);
	// ----------------------------------------------------------------
	// line drive
	// ----------------------------------------------------------------
	// quiet line at time zero
	initial begin
		rx_dv_out = 1'b0;
		rx_er_out = 1'b0;
		rx_nib_en_out = 1'b0;
		rxd_out = 4'hA;
	end
	// one nibble with its strobe, then the rest of the slot
	task automatic put_nib(input logic [3:0] nib, input logic er);
		rxd_out <= nib;
		rx_er_out <= er;
		rx_nib_en_out <= 1'b1;
		@(posedge clk_sys_in);
		rx_nib_en_out <= 1'b0;
		repeat (GAP - 1) @(posedge clk_sys_in);
	endtask : put_nib
	// mode 2: receive error inside, mode 3: zero pair before delimiter
	task automatic send_frame(input logic [7:0] fb[$], input int pre, input int mode);
		@(posedge clk_sys_in);
		rx_dv_out <= 1'b1;
		for (int i = 0; i < pre; i++) begin
			put_nib(4'h5, 1'b0);
			put_nib(4'h5, 1'b0);
		end
		if (mode == 3) begin
			put_nib(4'h0, 1'b0);
			put_nib(4'h0, 1'b0);
		end
		put_nib(4'h5, 1'b0);
		put_nib(4'hD, 1'b0);
		foreach (fb[i]) begin
			put_nib(fb[i][3:0], mode == 2 && i == 20);
			put_nib(fb[i][7:4], 1'b0);
		end
		rx_dv_out <= 1'b0;
		rxd_out <= ~rxd_out; // no stale nibble once released
	endtask : send_frame
endmodule : erfe_phy_model

// ---- tb/erfe_rx_bench.sv ----
`timescale 1ns/100ps
`include "erfe_defs.svh"
module erfe_rx_bench;
	typedef struct {logic [1:0] k; logic [31:0] v; logic [31:0] m;} erfe_note_t;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic rx_dv, rx_er, nib_en, fifo_wr, fifo_stat, desc_wr, irq, busy;
	logic [3:0] rxd;
	logic [31:0] fifo_data, rdata, ev, wv, hv;
	logic [15:0] desc;
	logic fifo_full = 1'b0;
	logic [31:0] ext_ev = 32'h0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	erfe_note_t notes[$];
	logic [7:0] fb[$];
	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	erfe_phy_model #(.GAP(4)) erfe_phy_model_i (.clk_sys_in(clk_sys_in), .rx_dv_out(rx_dv),
		.rx_er_out(rx_er), .rx_nib_en_out(nib_en), .rxd_out(rxd));
	erfe_rx erfe_rx_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .rx_dv_in(rx_dv), .rx_er_in(rx_er),
		.rx_nib_en_in(nib_en), .rxd_in(rxd), .fifo_wr_out(fifo_wr), .fifo_data_out(fifo_data),
		.fifo_stat_out(fifo_stat), .fifo_full_in(fifo_full), .desc_wr_out(desc_wr), .desc_out(desc),
		.ext_events_in(ext_ev), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .rx_busy_out(busy));
	// 250 MHz clock
	initial begin
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic close_out();
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		n_tests++;
		if ((got & msk) !== (exp & msk)) begin
			fail_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic note(input logic [1:0] k, input logic [31:0] v, input logic [31:0] m);
		notes.push_back('{k, v, m});
	endtask : note
	// oldest note against the result just seen
	task automatic pop(input logic [1:0] k, input logic [31:0] got);
		erfe_note_t n;
		if (notes.size() == 0) begin
			chk({30'h0, k}, 32'hFFFFFFFF, 32'hFFFFFFFF);
		end else begin
			n = notes.pop_front();
			chk({30'h0, k}, {30'h0, n.k}, 32'h3);
			chk(got, n.v, n.m);
		end
	endtask : pop
	// result watcher
	always @(posedge clk_sys_in) begin
		rd_d <= rd;
		if (fifo_wr) pop({1'b0, fifo_stat}, fifo_data);
		if (desc_wr) pop(2'h2, {16'h0000, desc});
		if (rd_d) pop(2'h3, rdata);
	end
	// hang guard
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		note(2'h3, e, m);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
	endtask : reg_read
	function automatic logic [31:0] crc32(input logic [7:0] b[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (b[i]) begin
			c = c ^ {24'h0, b[i]};
			for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		end
		return ~c;
	endfunction : crc32
	// 64-byte frame, mode 1 spoils the checksum, mode 3 must vanish
	task automatic frame(input logic [7:0] da, input int pre, input int mode, input logic [31:0] flags);
		logic [31:0] crc;
		fb = {};
		for (int i = 0; i < 60; i++) fb.push_back(i < 6 ? da : 8'($urandom));
		crc = crc32(fb) ^ (mode == 1 ? 32'h1 : 32'h0);
		for (int i = 0; i < 4; i++) fb.push_back(crc[8*i +: 8]);
		if (mode != 3) begin
			for (int i = 0; i < 16; i++) note(2'h0, {fb[4*i+3], fb[4*i+2], fb[4*i+1], fb[4*i]}, 32'hFFFFFFFF);
			note(2'h1, flags | 32'h40, 32'h6400FFFF);
			note(2'h2, 32'h0800, 32'h8800);
		end
		erfe_phy_model_i.send_frame(fb, pre, mode);
		for (int i = 0; i < 300 && (busy !== 1'b0 || notes.size() != 0); i++) @(posedge clk_sys_in);
		repeat (4) @(posedge clk_sys_in);
		chk(notes.size(), 32'h0, 32'hFFFFFFFF);
		chk({31'h0, busy}, 32'h1, 32'h1);
	endtask : frame
	// main sequence
	initial begin
		ev = $urandom(78848);
		repeat (16) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		reg_read(`ERFE_OFS_EVENT_FLAGS, 32'h0, 32'hFFFFFFFF);
		reg_read(12'h3FC, 32'h0, 32'hFFFFFFFF);
		hv = $urandom;
		reg_write(`ERFE_OFS_HASH_UPPER, hv);
		reg_write(`ERFE_OFS_HASH_LOWER, ~hv);
		reg_read(`ERFE_OFS_HASH_UPPER, hv, 32'hFFFFFFFF);
		reg_read(`ERFE_OFS_HASH_LOWER, ~hv, 32'hFFFFFFFF);
		@(posedge clk_sys_in);
		ext_ev <= ev;
		@(posedge clk_sys_in);
		ext_ev <= 32'h0;
		reg_read(`ERFE_OFS_EVENT_FLAGS, ev & `ERFE_EV_IMPL_MASK, 32'hFFFFFFFF);
		wv = $urandom;
		reg_write(`ERFE_OFS_EVENT_FLAGS, wv);
		reg_read(`ERFE_OFS_EVENT_FLAGS, ev & ~wv & `ERFE_EV_IMPL_MASK, 32'hFFFFFFFF);
		reg_write(`ERFE_OFS_EVENT_FLAGS, 32'hFFFFFFFF);
		reg_write(`ERFE_OFS_EVENT_MASK, 32'h1 << `ERFE_EV_RX_FRAME);
		reg_write(`ERFE_OFS_RX_CTRL, 32'h05EE0009);
		repeat (8) @(posedge clk_sys_in);
		frame(8'hFF, 7, 0, 32'h1 << `ERFE_ST_BCAST);
		chk({31'h0, irq}, 32'h1, 32'h1);
		reg_read(`ERFE_OFS_EVENT_FLAGS, 32'h03000000, 32'h03000000);
		reg_write(`ERFE_OFS_EVENT_FLAGS, 32'h1 << `ERFE_EV_RX_FRAME);
		reg_write(`ERFE_OFS_EVENT_FLAGS, 32'h0);
		reg_read(`ERFE_OFS_EVENT_FLAGS, 32'h1 << `ERFE_EV_RX_BUFFER, 32'hFFFFFFFF);
		chk({31'h0, irq}, 32'h0, 32'h1);
		frame(8'h01, 1, 0, 32'h1 << `ERFE_ST_MCAST);
		frame(8'h02, 0, 0, 32'h0);
		frame(8'h02, 7, 1, 32'h1 << `ERFE_ST_CRC);
		frame(8'h02, 7, 2, 32'h1 << `ERFE_ST_CRC);
		reg_read(`ERFE_OFS_CNT_CRC, 32'h2, 32'h0000FFFF);
		reg_write(`ERFE_OFS_EVENT_FLAGS, 32'hFFFFFFFF);
		reg_write(`ERFE_OFS_EVENT_MASK, 32'h0);
		frame(8'h02, 7, 3, 32'h0);
		reg_read(`ERFE_OFS_EVENT_FLAGS, 32'h0, 32'hFFFFFFFF);
		frame(8'h02, 2, 0, 32'h0);
		chk({31'h0, irq}, 32'h0, 32'h1);
		reg_read(`ERFE_OFS_EVENT_FLAGS, 32'h1 << `ERFE_EV_RX_FRAME, 32'h1 << `ERFE_EV_RX_FRAME);
		repeat (2) @(posedge clk_sys_in);
		chk(notes.size(), 32'h0, 32'hFFFFFFFF);
		close_out();
	end
endmodule : erfe_rx_bench
